// file: inc/fault_timer_defs.vh
// Offsets, fields, reset values and timing counts of the port fault timer
`ifndef FAULT_TIMER_DEFS_VH
`define FAULT_TIMER_DEFS_VH
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_TIMING 8'h08
`define OFS_STATUS 8'h0c
`define OFS_INT_STAT 8'h10
`define OFS_INT_MASK 8'h14
`define OFS_FB_CFG 8'h40
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_DET_EN 2
`define CTRL_CLS_EN 3
`define CMD_PWR_ON 0
`define CMD_PWR_OFF 1
`define CMD_RESET 2
`define TIM_FLT_LO 6
`define TIM_FLT_HI 7
`define TIM_INR_LO 4
`define TIM_INR_HI 5
`define FB_DBL_SEL 0
`define INT_OC 0
`define INT_INRUSH 1
`define INT_COOL_DONE 2
`define MODE_OFF 2'h0
`define MODE_MANUAL 2'h1
`define MODE_SEMI 2'h2
`define MODE_AUTO 2'h3
`define RST_CTRL 4'h0
`define RST_TIMING 8'h00
`define RST_FB_CFG 1'h0
`define RST_INT_MASK 3'h0
`define CLK_HZ 10000000
`define TICK_US 100
// Sized to the timer widths; must follow CLK_HZ and TICK_US by hand
`define TICK_CYC 12'd1000
`define TICKS_PER_MS 14'd10
`define DOWN_DIV 16
`define FLT_NOM_MS 14'd60
`define FLT_NOM_TICKS (`FLT_NOM_MS * `TICKS_PER_MS)
`define FLT_C0_MS 14'd60
`define FLT_C1_MS 14'd15
`define FLT_C2_MS 14'd30
`define FLT_C3_MS 14'd120
`define INR_C0_MS 14'd60
`define INR_C1_MS 14'd30
`define INR_C2_MS 14'd120
`define INR_C3_MS 14'd200
`define COOL_MS 14'd1000
`define COOL_TICKS (`COOL_MS * `TICKS_PER_MS)
`endif

// file: verilog/sync2.v
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module sync2
(
  input wire pclk, // Clock
  input wire presetn, // Asynchronous reset, active low
  input wire d, // Asynchronous level
  output reg q // Synchronised level
);
  reg meta_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync2

// file: verilog/tick_gen.v
// Free-running prescaler giving a one-cycle tick every PERIOD cycles
`timescale 1ns/100ps
module tick_gen
#(
  parameter W = 12,
  parameter [11:0] PERIOD = 12'd1000
)
(
  input wire pclk, // Clock
  input wire presetn, // Asynchronous reset, active low
  output reg tick // One-cycle pulse
);
  reg [W-1:0] cnt_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b0;
    end
    else if (cnt_r == PERIOD - 12'd1)
    begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // tick_gen

// file: verilog/port_fault_timer.v
// One channel of fault timing: overcurrent counter, inrush and cool-down
// Summary of operation
// R01: Count up at current limit; trip off
// R02: After trip, cool down; block turn-on meanwhile
// R03: Below limit count down at 1/16, floor zero
// R04: Clear counter on power-off, disconnect, fast shutdown
// R05: New fault time while running restarts timer
// R06: Semi-auto: cool-down end restarts detect if enabled
// R07: Reset command, off or manual aborts cool-down
// R08: Select bit zero: fixed nominal 60 ms time-out
// R09: Select bit one: time-out from two-bit field
// R10: Inrush period limits current; fault gives 1 s cool-down
// R11: After inrush cool-down need class and detect enable
// R12: Code-to-duration mappings are configurable constants
//
// The register addresses and the APB register port were chosen for this implementation.
`include "fault_timer_defs.vh"
`timescale 1ns/100ps
module port_fault_timer
#(
  parameter [13:0] FLT_NOM = `FLT_NOM_TICKS,
  parameter [13:0] FLT_C0 = `FLT_C0_MS * `TICKS_PER_MS,
  parameter [13:0] FLT_C1 = `FLT_C1_MS * `TICKS_PER_MS,
  parameter [13:0] FLT_C2 = `FLT_C2_MS * `TICKS_PER_MS,
  parameter [13:0] FLT_C3 = `FLT_C3_MS * `TICKS_PER_MS,
  parameter [13:0] INR_C0 = `INR_C0_MS * `TICKS_PER_MS,
  parameter [13:0] INR_C1 = `INR_C1_MS * `TICKS_PER_MS,
  parameter [13:0] INR_C2 = `INR_C2_MS * `TICKS_PER_MS,
  parameter [13:0] INR_C3 = `INR_C3_MS * `TICKS_PER_MS,
  parameter [13:0] COOL = `COOL_TICKS,
  parameter [11:0] TICK_PERIOD = `TICK_CYC
)
(
  input wire pclk, // APB clock, 10 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction, high for write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire at_current_limit, // Comparator: channel at operating limit
  input wire at_inrush_limit, // Comparator: channel at inrush limit
  input wire fast_shutdown_input, // Fast shutdown pin, active high
  input wire dc_disconnect, // DC disconnect event, one cycle
  input wire detect_ok, // Detection and class passed, one cycle
  output reg power_en_r, // Channel switch on
  output reg inrush_limit_en_r, // Select inrush current limit
  output reg detect_start_r, // Start detection cycle, one cycle
  output reg irq_r // Level interrupt
);
  localparam [3:0] ST_OFF = 4'b0001;
  localparam [3:0] ST_INRUSH = 4'b0010;
  localparam [3:0] ST_ON = 4'b0100;
  localparam [3:0] ST_COOL = 4'b1000;

  wire tick;
  wire operating_current_limit_s;
  wire iinr_s;
  wire oss_s;

  reg [3:0] ctrl_r;
  reg [7:0] timing_r;
  reg fb_sel_r;
  reg [2:0] int_stat_r;
  reg [2:0] int_mask_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [13:0] oc_cnt_r;
  reg [13:0] oc_cnt_nxt;
  reg [3:0] div_r;
  reg [13:0] tmr_r;
  reg [13:0] tmr_nxt;
  reg cool_inrush_r;
  reg cool_inrush_nxt;
  reg [2:0] ev_nxt;
  reg det_nxt;
  reg [31:0] rd_nxt;
  reg err_nxt;
  reg [13:0] flt_limit;
  reg [13:0] inr_limit;

  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire wr_ctrl = wr_acc & (paddr == `OFS_CTRL);
  wire wr_cmd = wr_acc & (paddr == `OFS_CMD);
  wire wr_tim = wr_acc & (paddr == `OFS_TIMING);
  wire wr_fb = wr_acc & (paddr == `OFS_FB_CFG);
  wire wr_ist = wr_acc & (paddr == `OFS_INT_STAT);
  wire wr_msk = wr_acc & (paddr == `OFS_INT_MASK);
  wire cmd_on = wr_cmd & pwdata[`CMD_PWR_ON];
  wire cmd_off = wr_cmd & pwdata[`CMD_PWR_OFF];
  wire cmd_rst = wr_cmd & pwdata[`CMD_RESET];
  wire [1:0] mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire [1:0] mode_w = pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire to_off_man = wr_ctrl &
    ((mode_w == `MODE_OFF) | (mode_w == `MODE_MANUAL));
  wire det_en = ctrl_r[`CTRL_DET_EN];
  wire cls_en = ctrl_r[`CTRL_CLS_EN];
  wire flt_chg = wr_tim &
    (pwdata[`TIM_FLT_HI:`TIM_FLT_LO] != timing_r[`TIM_FLT_HI:`TIM_FLT_LO]);
  wire inr_chg = wr_tim &
    (pwdata[`TIM_INR_HI:`TIM_INR_LO] != timing_r[`TIM_INR_HI:`TIM_INR_LO]);
  wire turn_on = cmd_on | (detect_ok & (mode != `MODE_OFF) &
    (mode != `MODE_MANUAL));
  wire down_tick = tick & (div_r == 4'hf);

  // Comparators and the shutdown pin are asynchronous to pclk
  sync2 u_sync_operating_current_limit
  (
    .pclk(pclk),
    .presetn(presetn),
    .d(at_current_limit),
    .q(operating_current_limit_s)
  );

  sync2 u_sync_iinr
  (
    .pclk(pclk),
    .presetn(presetn),
    .d(at_inrush_limit),
    .q(iinr_s)
  );

  sync2 u_sync_oss
  (
    .pclk(pclk),
    .presetn(presetn),
    .d(fast_shutdown_input),
    .q(oss_s)
  );

  tick_gen #(.W(12), .PERIOD(TICK_PERIOD)) u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Time-out selection; codes map through parameters
  always @*
  begin
    if (!fb_sel_r)
      flt_limit = FLT_NOM; // R08
    else
    begin
      case (timing_r[`TIM_FLT_HI:`TIM_FLT_LO]) // R09 R12
        2'h0: flt_limit = FLT_C0;
        2'h1: flt_limit = FLT_C1;
        2'h2: flt_limit = FLT_C2;
        default: flt_limit = FLT_C3;
      endcase
    end
    case (timing_r[`TIM_INR_HI:`TIM_INR_LO]) // R12
      2'h0: inr_limit = INR_C0;
      2'h1: inr_limit = INR_C1;
      2'h2: inr_limit = INR_C2;
      default: inr_limit = INR_C3;
    endcase
  end

  always @*
  begin
    state_nxt = state_r;
    oc_cnt_nxt = oc_cnt_r;
    tmr_nxt = tmr_r;
    cool_inrush_nxt = cool_inrush_r;
    ev_nxt = 3'h0;
    det_nxt = 1'b0;
    case (state_r)
      ST_OFF:
      begin
        oc_cnt_nxt = 14'h0000;
        if (turn_on & ~oss_s & ~cmd_rst & ~cmd_off)
        begin
          state_nxt = ST_INRUSH;
          tmr_nxt = 14'h0000;
        end
      end
      ST_INRUSH:
      begin
        if (inr_chg)
          tmr_nxt = 14'h0000;
        else if (tick)
          tmr_nxt = tmr_r + 14'h0001;
        if (tmr_r >= inr_limit)
        begin
          if (iinr_s)
          begin
            state_nxt = ST_COOL; // R10
            cool_inrush_nxt = 1'b1;
            tmr_nxt = 14'h0000;
            ev_nxt[`INT_INRUSH] = 1'b1;
          end
          else
            state_nxt = ST_ON;
        end
      end
      ST_ON:
      begin
        if (flt_chg)
          oc_cnt_nxt = 14'h0000; // R05
        else if (tick & operating_current_limit_s)
          oc_cnt_nxt = oc_cnt_r + 14'h0001; // R01
        else if (down_tick & ~operating_current_limit_s & (oc_cnt_r != 14'h0000))
          oc_cnt_nxt = oc_cnt_r - 14'h0001; // R03
        if (oc_cnt_r >= flt_limit)
        begin
          state_nxt = ST_COOL; // R01
          cool_inrush_nxt = 1'b0;
          tmr_nxt = 14'h0000;
          oc_cnt_nxt = 14'h0000;
          ev_nxt[`INT_OC] = 1'b1;
        end
      end
      ST_COOL:
      begin
        // Turn-on requests are simply dropped here
        if (tick)
          tmr_nxt = tmr_r + 14'h0001; // R02
        if (tmr_r >= COOL)
        begin
          state_nxt = ST_OFF;
          ev_nxt[`INT_COOL_DONE] = 1'b1;
          if (mode == `MODE_SEMI)
          begin
            if (cool_inrush_r)
              det_nxt = det_en & cls_en; // R11
            else
              det_nxt = det_en; // R06
          end
        end
      end
      default:
      begin
        state_nxt = ST_OFF;
      end
    endcase
    // Outside cool-down, forced turn-off overrides the state and counter set above
    if ((state_r != ST_COOL) &
        (cmd_off | cmd_rst | dc_disconnect | oss_s | to_off_man))
    begin
      state_nxt = ST_OFF;
      oc_cnt_nxt = 14'h0000; // R04
    end
    if ((state_r == ST_COOL) & (cmd_rst | to_off_man))
    begin
      state_nxt = ST_OFF; // R07
      tmr_nxt = 14'h0000;
      ev_nxt[`INT_COOL_DONE] = 1'b0;
      det_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_OFF;
      oc_cnt_r <= 14'h0000;
      tmr_r <= 14'h0000;
      div_r <= 4'h0;
      cool_inrush_r <= 1'b0;
      power_en_r <= 1'b0;
      inrush_limit_en_r <= 1'b0;
      detect_start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      oc_cnt_r <= oc_cnt_nxt;
      tmr_r <= tmr_nxt;
      cool_inrush_r <= cool_inrush_nxt;
      if (tick)
        div_r <= div_r + 4'h1; // R03
      power_en_r <= (state_nxt == ST_INRUSH) | (state_nxt == ST_ON);
      inrush_limit_en_r <= (state_nxt == ST_INRUSH); // R10
      detect_start_r <= det_nxt;
    end
  end

  // Register file
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `RST_CTRL;
      timing_r <= `RST_TIMING;
      fb_sel_r <= `RST_FB_CFG;
      int_mask_r <= `RST_INT_MASK;
      int_stat_r <= 3'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= pwdata[3:0];
      if (wr_tim)
        timing_r <= pwdata[7:0];
      if (wr_fb)
        fb_sel_r <= pwdata[`FB_DBL_SEL];
      if (wr_msk)
        int_mask_r <= pwdata[2:0];
      // A new event wins over a clear in the same cycle
      if (wr_ist)
        int_stat_r <= (int_stat_r & ~pwdata[2:0]) | ev_nxt;
      else
        int_stat_r <= int_stat_r | ev_nxt;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  always @*
  begin
    err_nxt = 1'b0;
    case (paddr)
      `OFS_CTRL: rd_nxt = {28'h0000000, ctrl_r};
      `OFS_CMD: rd_nxt = 32'h00000000;
      `OFS_TIMING: rd_nxt = {24'h000000, timing_r};
      `OFS_STATUS: rd_nxt = {14'h0000, oc_cnt_r, state_r};
      `OFS_INT_STAT: rd_nxt = {29'h00000000, int_stat_r};
      `OFS_INT_MASK: rd_nxt = {29'h00000000, int_mask_r};
      `OFS_FB_CFG: rd_nxt = {31'h00000000, fb_sel_r};
      default:
      begin
        rd_nxt = 32'h00000000;
        err_nxt = 1'b1;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata <= pwrite ? 32'h00000000 : rd_nxt;
        pslverr <= err_nxt;
      end
    end
  end
endmodule // port_fault_timer

// file: test/fault_timer_chk.sv
// Port-side assertions for the channel fault timer
`timescale 1ns/100ps
module fault_timer_chk
(
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB address
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire at_current_limit, // At operating limit
  input wire fast_shutdown_input, // Fast shutdown
  input wire power_en_r, // Channel on
  input wire inrush_limit_en_r, // Inrush period
  input wire detect_start_r // Detect restart
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_hold_a: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  unmapped_err_a: assert property (psel && penable && paddr == 8'h20
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  cmd_read_a: assert property (psel && penable && !pwrite && paddr == 8'h04
    |-> prdata == 32'h0) else $error("command reads nonzero");
  inrush_power_a: assert property (inrush_limit_en_r |-> power_en_r)
    else $error("inrush without power");
  start_inrush_a: assert property ($rose(power_en_r)
    |-> inrush_limit_en_r)
    else $error("power on skipped inrush");
  shutdown_off_a: assert property (fast_shutdown_input
    |-> ##[1:4] !power_en_r)
    else $error("shutdown ignored");
  limit_trip_a: assert property ($fell(power_en_r)
    && $past(at_current_limit)
    |-> $past(power_en_r, 8) && !$past(inrush_limit_en_r, 8))
    else $error("trip without a held limit");
  detect_pulse_a: assert property (detect_start_r |=> !detect_start_r)
    else $error("detect start not a pulse");
  cool_block_a: assert property ($fell(power_en_r)
    && $past(at_current_limit) && !fast_shutdown_input
    |=> !power_en_r [*8])
    else $error("turn-on during cool-down");
endmodule // fault_timer_chk

// file: test/pd_model.sv
// Powered device seen through the channel current comparators
`timescale 1ns/100ps
module pd_model
(
  input wire pclk, // Clock
  input wire power_en_r, // Channel on
  input wire inrush_limit_en_r, // Inrush period
  input wire detect_start_r, // Detect restart
  input wire ovl, // Bench: device overloads
  input wire inr_fault, // Bench: device fails inrush
  output wire at_current_limit, // At operating limit
  output wire at_inrush_limit, // At inrush limit
  output reg detect_ok // Detection passed
);
  reg d1 = 1'b0;
  // Load only draws current while powered, so limits cannot show when off
  assign at_current_limit = power_en_r & !inrush_limit_en_r & ovl;
  assign at_inrush_limit = inrush_limit_en_r & inr_fault;
  initial detect_ok = 1'b0;
  always @(posedge pclk)
  begin
    d1 <= detect_start_r;
    detect_ok <= d1;
  end
endmodule // pd_model

// file: test/pse_port_fault_timer_tb_top.sv
// Self-checking bench for the channel fault timer
`timescale 1ns/100ps
module pse_port_fault_timer_tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg fast_shutdown_input = 0, dc_disconnect = 0, ovl = 0, inr_fault = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rv;
  wire [31:0] prdata;
  wire pready, pslverr, at_current_limit, at_inrush_limit, detect_ok;
  wire power_en_r, inrush_limit_en_r, detect_start_r, irq_r;
  wire [2:0] ob = {detect_start_r, inrush_limit_en_r, power_en_r};
  int err_total = 0, samples_checked = 0, c, k, ds_n = 0;
  port_fault_timer #(.FLT_NOM(14'd8), .FLT_C1(14'd5), .INR_C0(14'd4),
    .COOL(14'd20), .TICK_PERIOD(12'd4)) port_fault_timer_i
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .at_current_limit(at_current_limit),
    .at_inrush_limit(at_inrush_limit),
    .fast_shutdown_input(fast_shutdown_input),
    .dc_disconnect(dc_disconnect),
    .detect_ok(detect_ok),
    .power_en_r(power_en_r),
    .inrush_limit_en_r(inrush_limit_en_r),
    .detect_start_r(detect_start_r),
    .irq_r(irq_r)
  );
  pd_model pd_model_i
  (
    .pclk(pclk),
    .power_en_r(power_en_r),
    .inrush_limit_en_r(inrush_limit_en_r),
    .detect_start_r(detect_start_r),
    .ovl(ovl),
    .inr_fault(inr_fault),
    .at_current_limit(at_current_limit),
    .at_inrush_limit(at_inrush_limit),
    .detect_ok(detect_ok)
  );
  always #50 pclk = ~pclk;
  always @(posedge pclk)
    if (detect_start_r === 1'b1)
      ds_n++;
  task test_done;
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e, input [127:0] n);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %0s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task rc(input [7:0] a, input [31:0] e, input [127:0] n);
    apb(a, 0, 0);
    chk(rv, e, n);
  endtask
  // Counts edges until the output, as sampled at an edge, reaches v
  task wv(input int i, input logic v);
    c = 0;
    while (ob[i] !== v && c < 3000)
    begin
      @(posedge pclk);
      c++;
    end
  endtask
  task t_regs;
    rc(8'h00, 0, "ctrl");
    rc(8'h08, 0, "timing");
    rc(8'h40, 0, "fb_cfg");
    rc(8'h14, 0, "mask");
    rc(8'h04, 0, "cmd");
    apb(8'h08, 1, 32'hf0);
    rc(8'h08, 32'hf0, "timing");
    apb(8'h20, 1, 32'h5);
    chk(pslverr, 1, "slverr");
    rc(8'h20, 0, "unmapped");
  endtask
  task t_trip(input [31:0] fb, input int lo, input int hi);
    apb(8'h40, 1, fb);
    apb(8'h08, 1, 32'h40);
    ovl <= 1;
    apb(8'h04, 1, 1);
    wv(1, 1);
    wv(1, 0);
    wv(0, 0);
    chk(c >= lo && c <= hi, 1, "trip");
    ovl <= 0;
    apb(8'h04, 1, 1);
    repeat (2) @(posedge pclk);
    chk(power_en_r, 0, "cool");
  endtask
  task t_count;
    apb(8'h08, 1, 0);
    apb(8'h00, 1, 6);
    apb(8'h04, 1, 1);
    wv(1, 1);
    wv(1, 0);
    ovl <= 1;
    repeat (60) @(posedge pclk);
    ovl <= 0;
    apb(8'h0c, 0, 0);
    k = rv[17:4];
    chk(k > 8, 1, "count_up");
    repeat (130) @(posedge pclk);
    apb(8'h0c, 0, 0);
    chk(k - rv[17:4] > 0 && k - rv[17:4] < 4, 1, "count_down");
    repeat (1200) @(posedge pclk);
    rc(8'h0c, 4, "floor");
    ovl <= 1;
    repeat (40) @(posedge pclk);
    ovl <= 0;
    apb(8'h08, 1, 32'h80);
    rc(8'h0c, 4, "restart");
    ovl <= 1;
    repeat (40) @(posedge pclk);
    ovl <= 0;
    dc_disconnect <= 1;
    @(posedge pclk);
    dc_disconnect <= 0;
    rc(8'h0c, 1, "disconnect");
    apb(8'h04, 1, 1);
    wv(0, 1);
    fast_shutdown_input <= 1;
    wv(0, 0);
    chk(c < 6, 1, "shutdown");
    fast_shutdown_input <= 0;
  endtask
  task t_inrush;
    // Shutdown level must clear the synchroniser before the next turn-on
    repeat (4) @(posedge pclk);
    inr_fault <= 1;
    apb(8'h10, 1, 7);
    apb(8'h04, 1, 1);
    wv(1, 1);
    wv(0, 0);
    k = ds_n;
    apb(8'h04, 1, 1);
    repeat (2) @(posedge pclk);
    chk(power_en_r, 0, "inrush_cool");
    repeat (150) @(posedge pclk);
    chk(ds_n, k, "no_class");
    rc(8'h10, 6, "int_stat");
    apb(8'h00, 1, 32'he);
    apb(8'h04, 1, 1);
    wv(0, 1);
    wv(0, 0);
    wv(2, 1);
    chk(c < 120, 1, "class_det");
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    test_done;
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs;
    apb(8'h00, 1, 6);
    apb(8'h14, 1, 1);
    t_trip(0, 26, 40);
    chk(irq_r, 1, "irq");
    wv(2, 1);
    chk(c < 120, 1, "detect");
    wv(0, 1);
    chk(c < 10, 1, "repower");
    apb(8'h04, 1, 2);
    rc(8'h10, 5, "int_stat");
    apb(8'h10, 1, 7);
    rc(8'h10, 0, "int_clear");
    chk(irq_r, 0, "irq");
    t_trip(1, 14, 26);
    k = ds_n;
    apb(8'h00, 1, 1);
    repeat (120) @(posedge pclk);
    chk(ds_n, k, "abort");
    rc(8'h10, 1, "int_abort");
    t_count;
    t_inrush;
    test_done;
  end
endmodule // pse_port_fault_timer_tb_top
bind port_fault_timer fault_timer_chk fault_timer_chk_i
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .at_current_limit(at_current_limit),
  .fast_shutdown_input(fast_shutdown_input),
  .power_en_r(power_en_r),
  .inrush_limit_en_r(inrush_limit_en_r),
  .detect_start_r(detect_start_r)
);
